// File: core/uecr_pkg.sv
package uecr_pkg;
	// register byte addresses (plain port, 16-bit words on 4-byte steps)
	localparam logic [7:0] UECR_A_MODE = 8'h00;
	localparam logic [7:0] UECR_A_CMD = 8'h04;
	localparam logic [7:0] UECR_A_EVT = 8'h08;
	localparam logic [7:0] UECR_A_BRKCNT = 8'h0c;
	localparam logic [7:0] UECR_A_MAXIDLE = 8'h10;
	localparam logic [7:0] UECR_A_IDLECNT = 8'h14;
	localparam logic [7:0] UECR_A_BRKERR = 8'h18;
	localparam logic [7:0] UECR_A_REJ = 8'h1c;
	localparam logic [7:0] UECR_A_STATUS = 8'h20;
	localparam logic [2:0] UECR_A_TBL_HI = 3'h2; // entries at 8'h40 + 4*i
	// emulation mode register fields
	localparam int UECR_M_ENT = 11;
	localparam int UECR_M_ENR = 10;
	localparam int UECR_M_DIV_LO = 6;
	localparam logic [15:0] UECR_MODE_RST = 16'h0000;
	// control character entry fields
	localparam int UECR_C_VALID = 15;
	localparam int UECR_C_REJ = 14;
	localparam int UECR_C_RDY = 13;
	localparam int UECR_C_INT = 12;
	localparam int UECR_FLOW_IDX = 7;
	localparam int UECR_NCHAR = 8;
	// event bits
	localparam int UECR_E_RX = 0;
	localparam int UECR_E_TX = 1;
	localparam int UECR_E_CCR = 2;
	localparam int UECR_E_BRK = 3;
	localparam logic [15:0] UECR_WORD_RST = 16'h0000;
	localparam logic [15:0] UECR_IDLE_LAST = 16'h0001;
	localparam logic [7:0] UECR_BRK_CHAR = 8'h00;
	// commands
	typedef enum logic [1:0] {
		UECR_CMD_NONE = 2'b00,
		UECR_CMD_STOP = 2'b01,
		UECR_CMD_RESTART = 2'b10,
		UECR_CMD_HUNT = 2'b11
	} uecr_cmd_e;
	typedef enum logic [1:0] {
		UECR_TX_OFF = 2'b00,
		UECR_TX_RUN = 2'b01,
		UECR_TX_BREAK = 2'b10,
		UECR_TX_STOP = 2'b11
	} uecr_tx_e;
	typedef enum logic [1:0] {
		UECR_RX_OFF = 2'b00,
		UECR_RX_IDLE = 2'b01,
		UECR_RX_OPEN = 2'b10,
		UECR_RX_HUNT = 2'b11
	} uecr_rx_e;
endpackage : uecr_pkg

// File: core/uecr_char_match.sv
`timescale 1ns/1ps
module uecr_char_match import uecr_pkg::*; (
	input wire logic [UECR_NCHAR-1:0][15:0] tbl, // control character table
	input wire logic [7:0] chr, // incoming character
	output logic hit, // some valid entry matches
	output logic hit_rej // a matching entry is a reject entry
);
	logic [UECR_NCHAR-1:0] m;
	logic [UECR_NCHAR-1:0] r;

	// one comparator per entry; a reject match wins over a store match
	for (genvar i = 0; i < UECR_NCHAR; i++) begin : g_ent
		assign m[i] = tbl[i][UECR_C_VALID] && (tbl[i][7:0] == chr);
		assign r[i] = m[i] && tbl[i][UECR_C_REJ];
	end

	assign hit = |m;
	assign hit_rej = |r;
endmodule : uecr_char_match

// File: core/uecr_poll_div.sv
`timescale 1ns/1ps
module uecr_poll_div import uecr_pkg::*; (
	input wire logic sys_clk, // system clock
	input wire logic resetn, // sync reset, active low
	input wire logic run, // divider active
	input wire logic tick, // baud generator pulse
	input wire logic [3:0] div, // reload value
	output logic expire // one-cycle poll pulse
);
	typedef struct packed {
		logic [3:0] cnt;
	} uecr_div_s;
	uecr_div_s s;
	uecr_div_s next_s;

	// poll fires when the down-counter is at zero on a tick
	assign expire = run && tick && (s.cnt == 4'h0);

	// reload on expiry; parked at the reload value while idle
	always_comb begin
		next_s = s;
		if (!run) begin
			next_s.cnt = div;
		end else if (tick) begin
			next_s.cnt = (s.cnt == 4'h0) ? div : s.cnt - 4'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : uecr_poll_div

// File: core/uecr_ctrl.sv
// Overview of operation
// - tx polls first descriptor at divider rate
// - stop command sends break count then halts
// - restart resumes at current tx descriptor
// - break is zero char; then idle/data
// - breaks queue behind pending characters
// - rx starts at first descriptor
// - hunt closes open buffer, raises rx event
// - after hunt resume after one idle
// - match against eight 16-bit table entries
// - store match: write, close, next descriptor
// - reject match: save char, control event
// - unread rejected char gets overwritten
// - flow entry ready set, device clears
// - empty poll is idle; max idles close
// - idle without open buffer is silent
// - data character reloads idle counter
// - break bumps counter, sets break event
// - break while open closes; counted once
// - full buffer closes, next descriptor
// - tx divider down-counter paces polling
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module uecr_ctrl import uecr_pkg::*; (
	input wire logic sys_clk, // system clock, 100 MHz
	input wire logic resetn, // sync reset, active low
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [15:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [15:0] reg_rdata, // read data, cycle after strobe
	input wire logic brg_tick, // baud generator pulse
	input wire logic txd_valid, // tx descriptor char available
	input wire logic [7:0] txd_data, // tx descriptor char
	input wire logic txd_last, // char is last of its buffer
	input wire logic txd_wrap, // current tx descriptor wraps
	input wire logic txd_int, // current tx descriptor wants event
	output logic txd_ready, // tx char taken
	output logic [2:0] tx_desc_idx, // current tx descriptor
	output logic hrx_valid, // char toward host receive fifo
	output logic [7:0] hrx_data, // char value
	output logic hrx_break, // char is a break
	input wire logic hrx_ready, // host receive fifo accepts
	input wire logic htx_valid, // host transmit fifo not empty
	input wire logic [7:0] htx_data, // host transmit fifo head
	input wire logic htx_break, // head is a break sequence
	output logic htx_ready, // pop host transmit fifo
	input wire logic host_set_break, // host line control set-break
	input wire logic rxb_last, // next write fills rx buffer
	input wire logic rxd_wrap, // current rx descriptor wraps
	input wire logic rxd_int, // current rx descriptor wants event
	output logic rxb_wr, // write char into rx buffer
	output logic [7:0] rxb_data, // char written
	output logic rxb_close, // close current rx buffer
	output logic rxb_ctrl, // closed on control char
	output logic rxb_idle, // closed on idles
	output logic rxb_brk, // break received flag
	output logic [2:0] rx_desc_idx // current rx descriptor
);
	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] brk_cnt;
		logic [15:0] max_idle;
		logic [15:0] idle_cnt;
		logic [15:0] brk_err;
		logic [7:0] rej_char;
		logic [3:0] evt;
		logic [UECR_NCHAR-1:0][15:0] tbl;
		uecr_cmd_e cmd;
		uecr_tx_e tx;
		logic restart;
		logic [15:0] brk_left;
		logic arm;
		logic ov;
		logic [7:0] od;
		logic ob;
		logic ofl;
		logic [2:0] txi;
		logic [2:0] rxi;
		uecr_rx_e rx;
		logic brk_seq;
		logic brk_prev;
		logic [15:0] rdata;
		logic bw;
		logic [7:0] bd;
		logic bc;
		logic bcc;
		logic bid;
		logic bbr;
	} uecr_st_s;
	uecr_st_s s;
	uecr_st_s next_s;

	logic ent, enr, p, cmd_go, can_load, flow_req, load_data, pop, is_data;
	logic hit, hit_rej, brk_now, brk_edge;
	logic cl_ctrl, cl_idle, cl_brk, cl_full, cl_hunt;
	logic [3:0] ev_set;

	assign ent = s.mode[UECR_M_ENT];
	assign enr = s.mode[UECR_M_ENR];

	uecr_poll_div u_div (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.run(ent || enr),
		.tick(brg_tick),
		.div(s.mode[UECR_M_DIV_LO+3:UECR_M_DIV_LO]),
		.expire(p)
	);

	uecr_char_match u_match (
		.tbl(s.tbl),
		.chr(htx_data),
		.hit(hit),
		.hit_rej(hit_rej)
	);

	// handshakes; commands wait for a poll-free cycle so descriptor work is whole
	assign cmd_go = (s.cmd != UECR_CMD_NONE) && !p;
	assign can_load = !s.ov || hrx_ready;
	assign flow_req = s.tbl[UECR_FLOW_IDX][UECR_C_RDY] && !s.tbl[UECR_FLOW_IDX][UECR_C_REJ]
		&& !(s.ov && s.ofl);
	assign load_data = (s.tx == UECR_TX_RUN) && ent && can_load && !flow_req && s.arm
		&& txd_valid;
	assign txd_ready = load_data;
	assign pop = p && enr && htx_valid && (s.rx != UECR_RX_OFF);
	assign htx_ready = pop;
	assign is_data = pop && !htx_break;
	// a long break holds brk_now high, so only its first edge counts
	assign brk_now = host_set_break || s.brk_seq;
	assign brk_edge = brk_now && !s.brk_prev;

	// outputs come straight from the state flops
	assign hrx_valid = s.ov;
	assign hrx_data = s.od;
	assign hrx_break = s.ob;
	assign tx_desc_idx = s.txi;
	assign rx_desc_idx = s.rxi;
	assign reg_rdata = s.rdata;
	assign rxb_wr = s.bw;
	assign rxb_data = s.bd;
	assign rxb_close = s.bc;
	assign rxb_ctrl = s.bcc;
	assign rxb_idle = s.bid;
	assign rxb_brk = s.bbr;

	// next-state: transmitter, receiver, commands, then register port
	always_comb begin
		next_s = s;
		ev_set = 4'h0;
		cl_ctrl = 1'b0;
		cl_idle = 1'b0;
		cl_brk = 1'b0;
		cl_full = 1'b0;
		cl_hunt = 1'b0;
		next_s.rdata = UECR_WORD_RST;
		next_s.bw = 1'b0;
		next_s.bc = 1'b0;
		next_s.bcc = 1'b0;
		next_s.bid = 1'b0;
		next_s.bbr = 1'b0;
		// output slot drained; flow char done clears its ready bit
		if (s.ov && hrx_ready) begin
			next_s.ov = 1'b0;
			if (s.ofl) begin
				next_s.ofl = 1'b0;
				next_s.tbl[UECR_FLOW_IDX][UECR_C_RDY] = 1'b0;
				ev_set[UECR_E_TX] = s.tbl[UECR_FLOW_IDX][UECR_C_INT];
			end
		end
		case (s.tx)
			UECR_TX_OFF: begin
				if (ent) begin
					next_s.tx = UECR_TX_RUN;
				end
			end
			UECR_TX_RUN: begin
				if (p) begin
					next_s.arm = 1'b1;
				end
				if (ent && can_load && flow_req) begin
					next_s.ov = 1'b1;
					next_s.od = s.tbl[UECR_FLOW_IDX][7:0];
					next_s.ob = 1'b0;
					next_s.ofl = 1'b1;
				end else if (load_data) begin
					next_s.ov = 1'b1;
					next_s.od = txd_data;
					next_s.ob = 1'b0;
					next_s.arm = 1'b0;
					if (txd_last) begin
						next_s.txi = txd_wrap ? 3'h0 : s.txi + 3'h1;
						ev_set[UECR_E_TX] = txd_int;
					end
				end
			end
			UECR_TX_BREAK: begin
				// breaks wait for the slot, so queued chars go first
				if (s.brk_left == UECR_WORD_RST) begin
					next_s.tx = s.restart ? UECR_TX_RUN : UECR_TX_STOP;
					next_s.restart = 1'b0;
				end else if (can_load) begin
					next_s.ov = 1'b1;
					next_s.od = UECR_BRK_CHAR;
					next_s.ob = 1'b1;
					next_s.ofl = 1'b0;
					next_s.brk_left = s.brk_left - 16'h0001;
				end
			end
			UECR_TX_STOP: begin
				next_s.arm = 1'b0;
			end
			default: begin
				next_s.tx = UECR_TX_OFF;
			end
		endcase
		// receiver
		if (!enr) begin
			next_s.rx = UECR_RX_OFF;
		end else if (s.rx == UECR_RX_OFF) begin
			next_s.rx = UECR_RX_IDLE;
		end else if (p) begin
			next_s.brk_seq = htx_valid && htx_break;
			if (s.rx == UECR_RX_HUNT) begin
				if (!htx_valid) begin
					next_s.rx = UECR_RX_IDLE;
				end
			end else if (is_data) begin
				if (hit && hit_rej) begin
					next_s.rej_char = htx_data;
					ev_set[UECR_E_CCR] = 1'b1;
				end else begin
					next_s.bw = 1'b1;
					next_s.bd = htx_data;
					next_s.rx = UECR_RX_OPEN;
					next_s.idle_cnt = s.max_idle;
					cl_ctrl = hit;
					cl_full = rxb_last;
				end
			end else if (!htx_valid && s.rx == UECR_RX_OPEN) begin
				// a zero max idle wraps the counter, giving the longest wait
				if (s.idle_cnt == UECR_IDLE_LAST) begin
					cl_idle = 1'b1;
				end else begin
					next_s.idle_cnt = s.idle_cnt - 16'h0001;
				end
			end
		end
		next_s.brk_prev = brk_now;
		if (brk_edge) begin
			next_s.brk_err = s.brk_err + 16'h0001;
			ev_set[UECR_E_BRK] = 1'b1;
			cl_brk = (next_s.rx == UECR_RX_OPEN);
		end
		// channel commands
		if (cmd_go) begin
			next_s.cmd = UECR_CMD_NONE;
			case (s.cmd)
				UECR_CMD_STOP: begin
					next_s.tx = UECR_TX_BREAK;
					next_s.brk_left = s.brk_cnt;
					next_s.restart = 1'b0;
				end
				UECR_CMD_RESTART: begin
					if (s.tx == UECR_TX_BREAK) begin
						next_s.restart = 1'b1;
					end else begin
						next_s.tx = UECR_TX_RUN;
					end
				end
				UECR_CMD_HUNT: begin
					cl_hunt = (next_s.rx == UECR_RX_OPEN);
					if (next_s.rx != UECR_RX_OFF) begin
						next_s.rx = UECR_RX_HUNT;
					end
				end
				default: begin
					next_s.cmd = UECR_CMD_NONE;
				end
			endcase
		end
		// buffer close, any reason; descriptor advances with wrap
		if (cl_ctrl || cl_idle || cl_brk || cl_full || cl_hunt) begin
			next_s.bc = 1'b1;
			next_s.bcc = cl_ctrl;
			next_s.bid = cl_idle;
			next_s.bbr = cl_brk;
			next_s.rxi = rxd_wrap ? 3'h0 : s.rxi + 3'h1;
			ev_set[UECR_E_RX] = rxd_int;
			if (next_s.rx != UECR_RX_HUNT) begin
				next_s.rx = UECR_RX_IDLE;
			end
		end
		// register port; writes land after hardware clears, so a set wins
		if (reg_wr) begin
			case (reg_addr)
				UECR_A_MODE: next_s.mode = reg_wdata;
				UECR_A_CMD: begin
					if (s.cmd == UECR_CMD_NONE) begin
						next_s.cmd = uecr_cmd_e'(reg_wdata[1:0]);
					end
				end
				UECR_A_EVT: next_s.evt = s.evt & ~reg_wdata[3:0];
				UECR_A_BRKCNT: next_s.brk_cnt = reg_wdata;
				UECR_A_MAXIDLE: next_s.max_idle = reg_wdata;
				UECR_A_BRKERR: next_s.brk_err = reg_wdata;
				default: begin
					if (reg_addr[7:5] == UECR_A_TBL_HI && reg_addr[1:0] == 2'h0) begin
						next_s.tbl[reg_addr[4:2]] = reg_wdata;
					end
				end
			endcase
		end
		next_s.evt = next_s.evt | ev_set;
		if (reg_rd) begin
			case (reg_addr)
				UECR_A_MODE: next_s.rdata = s.mode;
				UECR_A_CMD: next_s.rdata = {14'h0000, s.cmd};
				UECR_A_EVT: next_s.rdata = {12'h000, s.evt};
				UECR_A_BRKCNT: next_s.rdata = s.brk_cnt;
				UECR_A_MAXIDLE: next_s.rdata = s.max_idle;
				UECR_A_IDLECNT: next_s.rdata = s.idle_cnt;
				UECR_A_BRKERR: next_s.rdata = s.brk_err;
				UECR_A_REJ: next_s.rdata = {8'h00, s.rej_char};
				UECR_A_STATUS: next_s.rdata = {5'h00, s.tx, s.rx, s.txi, s.rxi,
					s.cmd != UECR_CMD_NONE};
				default: begin
					if (reg_addr[7:5] == UECR_A_TBL_HI && reg_addr[1:0] == 2'h0) begin
						next_s.rdata = s.tbl[reg_addr[4:2]];
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	property p_tx_start;
		(s.tx == UECR_TX_OFF && ent) |=> (s.tx == UECR_TX_RUN && s.txi == 3'h0);
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("tx did not start");

	property p_stop_load;
		(cmd_go && s.cmd == UECR_CMD_STOP) |=>
			(s.tx == UECR_TX_BREAK && s.brk_left == $past(s.brk_cnt));
	endproperty
	a_stop_load: assert property (p_stop_load) else $error("stop not taken");

	property p_restart;
		(cmd_go && s.cmd == UECR_CMD_RESTART && s.tx == UECR_TX_STOP) |=>
			(s.tx == UECR_TX_RUN && $stable(s.txi));
	endproperty
	a_restart: assert property (p_restart) else $error("restart lost place");

	property p_brk_zero;
		hrx_valid && hrx_break |-> hrx_data == UECR_BRK_CHAR;
	endproperty
	a_brk_zero: assert property (p_brk_zero) else $error("break char not zero");

	property p_slot_hold;
		(s.ov && !hrx_ready) |=> (hrx_valid && $stable(hrx_data) && $stable(hrx_break));
	endproperty
	a_slot_hold: assert property (p_slot_hold) else $error("pending char overtaken");

	property p_hunt_close;
		(cmd_go && s.cmd == UECR_CMD_HUNT && s.rx == UECR_RX_OPEN && !brk_edge) |=>
			(rxb_close && s.rx == UECR_RX_HUNT);
	endproperty
	a_hunt_close: assert property (p_hunt_close) else $error("hunt did not close");

	property p_hunt_quiet;
		(s.rx == UECR_RX_HUNT) |=> !rxb_wr;
	endproperty
	a_hunt_quiet: assert property (p_hunt_quiet) else $error("write during hunt");

	property p_reject;
		(is_data && hit && hit_rej && s.rx != UECR_RX_HUNT) |=>
			(s.rej_char == $past(htx_data) && s.evt[UECR_E_CCR] && !rxb_wr);
	endproperty
	a_reject: assert property (p_reject) else $error("reject not stored");

	property p_idle_close;
		(p && enr && !htx_valid && s.rx == UECR_RX_OPEN && s.idle_cnt == UECR_IDLE_LAST) |=>
			(rxb_close && rxb_idle);
	endproperty
	a_idle_close: assert property (p_idle_close) else $error("idle close missed");

	property p_idle_silent;
		(s.rx == UECR_RX_IDLE && !cmd_go && !is_data) |=> !rxb_close;
	endproperty
	a_idle_silent: assert property (p_idle_silent) else $error("close with no buffer");

	property p_brk_count;
		(brk_edge && !(reg_wr && reg_addr == UECR_A_BRKERR)) |=>
			(s.brk_err == $past(s.brk_err) + 16'h0001 && s.evt[UECR_E_BRK]);
	endproperty
	a_brk_count: assert property (p_brk_count) else $error("break not counted");

	property p_cmd_hold;
		(s.cmd != UECR_CMD_NONE && !cmd_go) |=> $stable(s.cmd);
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command overwritten");

	c_break_then_run: cover property (s.tx == UECR_TX_BREAK ##1 s.tx == UECR_TX_RUN);
	c_idle_close: cover property (rxb_close && rxb_idle);
	c_hunt: cover property (s.rx == UECR_RX_HUNT ##[1:50] s.rx == UECR_RX_IDLE);
	c_reject: cover property (s.evt[UECR_E_CCR]);
endmodule : uecr_ctrl

// File: bench/uecr_host_model.sv
`timescale 1ns/1ps
module uecr_host_model import uecr_pkg::*; (
	input wire logic sys_clk, // system clock
	input wire logic resetn, // sync reset, active low
	input wire logic hrx_valid, // char from the device
	input wire logic [7:0] hrx_data, // char value
	input wire logic hrx_break, // char is a break
	output logic hrx_ready, // host receive fifo accepts
	output logic htx_valid, // host transmit fifo not empty
	output logic [7:0] htx_data, // head of host transmit fifo
	output logic htx_break, // head is a break sequence
	input wire logic htx_ready, // device pops the head
	output logic host_set_break // line control set-break
);
	logic [8:0] tx_q[$]; // host transmit fifo, break flag on top
	logic [8:0] rx_log[$]; // everything the device delivered
	int n_got = 0; // length of rx_log
	logic stall = 1'b0; // keep the receive fifo full
	initial begin
		hrx_ready = 1'b0;
		htx_valid = 1'b0;
		htx_data = 8'h00;
		htx_break = 1'b0;
		host_set_break = 1'b0;
	end
	// the host writes one character into its transmit fifo
	task automatic send(input logic [7:0] d, input logic b);
		tx_q.push_back({b, d});
	endtask : send
	// the host toggles its set-break line control bit
	task automatic line_break(input logic v);
		host_set_break <= v;
	endtask : line_break
	// pop and log at the edge, present the new head just after it
	always @(posedge sys_clk) begin
		if (htx_valid && htx_ready)
			void'(tx_q.pop_front());
		if (hrx_valid && hrx_ready) begin
			rx_log.push_back({hrx_break, hrx_data});
			n_got++;
		end
		hrx_ready <= resetn && !stall;
		htx_valid <= tx_q.size() != 0;
		htx_data <= (tx_q.size() != 0) ? tx_q[0][7:0] : ~htx_data; // empty fifo shows no stale char
		htx_break <= (tx_q.size() != 0) && tx_q[0][8];
	end
endmodule : uecr_host_model

// File: bench/tb.sv
`timescale 1ns/1ps
module tb import uecr_pkg::*;;
	localparam int LIMIT = 20000; // the whole sequence needs a few hundred cycles
	typedef struct packed {logic [7:0] a; logic [15:0] w; logic [15:0] e;} uecr_row_s;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic brg_tick = 1'b0;
	logic txd_valid = 1'b0;
	logic [7:0] txd_data = 8'h20;
	logic rxb_last = 1'b0;
	logic rxd_int = 1'b1; // rx descriptor event enable
	logic txd_wrap, rxd_wrap;
	logic [15:0] reg_rdata;
	logic txd_last, txd_ready, hrx_valid, hrx_break, hrx_ready, htx_valid, htx_break, htx_ready;
	logic host_set_break, rxb_wr, rxb_close, rxb_ctrl, rxb_idle, rxb_brk;
	logic [2:0] tx_desc_idx, rx_desc_idx;
	logic [7:0] hrx_data, htx_data, rxb_data;
	int num_errors = 0, checks_done = 0, cycles = 0, n_wr = 0, n_close = 0, k, nb, ntx;
	logic [2:0] close_f = 3'h0; // ctrl, idle, brk flags of the last close
	logic [7:0] last_wr = 8'h00;
	logic [7:0] tx_q[$]; // chars taken from the tx descriptors
	// register, written value, value read back
	uecr_row_s rows[13] = '{'{UECR_A_EVT, 16'hffff, 16'h0000}, '{UECR_A_MODE, 16'h03c0, 16'h03c0},
		'{UECR_A_BRKCNT, 16'h1234, 16'h1234}, '{UECR_A_MAXIDLE, 16'hbeef, 16'hbeef},
		'{UECR_A_MAXIDLE, 16'h0000, 16'h0000}, '{UECR_A_BRKERR, 16'h0005, 16'h0005},
		'{UECR_A_BRKERR, 16'h0000, 16'h0000}, '{UECR_A_IDLECNT, 16'hffff, 16'h0000},
		'{UECR_A_REJ, 16'h00ff, 16'h0000}, '{UECR_A_STATUS, 16'hffff, 16'h0000},
		'{8'h3c, 16'h5555, 16'h0000}, '{8'h54, 16'h4099, 16'h4099}, '{8'h5c, 16'h0000, 16'h0000}};

	uecr_ctrl dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.brg_tick, .txd_valid, .txd_data, .txd_last, .txd_wrap, .txd_int(1'b1), .txd_ready,
		.tx_desc_idx, .hrx_valid, .hrx_data, .hrx_break, .hrx_ready, .htx_valid, .htx_data,
		.htx_break, .htx_ready, .host_set_break, .rxb_last, .rxd_wrap, .rxd_int,
		.rxb_wr, .rxb_data, .rxb_close, .rxb_ctrl, .rxb_idle, .rxb_brk, .rx_desc_idx);
	uecr_host_model h (.sys_clk, .resetn, .hrx_valid, .hrx_data, .hrx_break, .hrx_ready,
		.htx_valid, .htx_data, .htx_break, .htx_ready, .host_set_break);

	always #5 sys_clk = ~sys_clk;
	assign txd_last = txd_data[1:0] == 2'b11; // every fourth char ends a descriptor
	// short rings, so that both index wraps are reached
	assign txd_wrap = tx_desc_idx == 3'h1;
	assign rxd_wrap = rx_desc_idx == 3'h4;

	// tick every other cycle so commands find cycles without a poll
	always @(posedge sys_clk) begin
		brg_tick <= resetn && !brg_tick;
		if (txd_valid && txd_ready) begin
			tx_q.push_back(txd_data);
			txd_data <= txd_data + 8'h01;
		end
		if (rxb_wr) begin
			n_wr++;
			last_wr = rxb_data;
		end
		if (rxb_close) begin
			n_close++;
			close_f = {rxb_ctrl, rxb_idle, rxb_brk};
		end
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			summarize();
		end
	end

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// one write cycle, then a free cycle so strobes never merge
	task automatic wr(input logic [7:0] a, input logic [15:0] w);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(n, reg_rdata, e);
		@(posedge sys_clk);
	endtask : rdchk
	// bounded wait on a counter; a shortfall shows in the check after it
	task automatic await(ref int c, input int n);
		for (int i = 0; i < 500 && c < n; i++)
			@(posedge sys_clk);
	endtask : await
	task automatic summarize();
		$display("mismatches %0d comparisons %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	initial begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		chk("tx index", 16'(tx_desc_idx), 16'h0000);
		chk("rx index", 16'(rx_desc_idx), 16'h0000);
		@(posedge sys_clk);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rdchk($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].e);
		end
		// receive: entry 2 stores, entries 3 and 4 reject
		wr(8'h48, 16'h800d);
		wr(8'h4c, 16'hc013);
		wr(8'h50, 16'hc011);
		wr(UECR_A_MODE, 16'h0400);
		repeat (20) @(posedge sys_clk);
		chk("idle closes", 16'(n_close), 16'h0000);
		h.send(8'h41, 1'b0);
		h.send(8'h0d, 1'b0);
		await(n_close, 1);
		chk("store data", 16'(last_wr), 16'h000d);
		chk("store writes", 16'(n_wr), 16'h0002);
		chk("store flags", 16'(close_f), 16'h0004);
		chk("rx index", 16'(rx_desc_idx), 16'h0001);
		// a second reject overwrites the unread first one
		h.send(8'h13, 1'b0);
		h.send(8'h11, 1'b0);
		repeat (20) @(posedge sys_clk);
		chk("reject writes", 16'(n_wr), 16'h0002);
		rdchk("rejected char", UECR_A_REJ, 16'h0011);
		rdchk("events", UECR_A_EVT, 16'h0005);
		wr(UECR_A_EVT, 16'h000f);
		// a long break while a buffer is open counts once
		h.send(8'h42, 1'b0);
		await(n_wr, 3);
		h.line_break(1'b1);
		repeat (40) @(posedge sys_clk);
		h.line_break(1'b0);
		chk("break flags", 16'(close_f), 16'h0001);
		rdchk("break count", UECR_A_BRKERR, 16'h0001);
		// a break sequence from the host fifo with no buffer open: counted, nothing closed
		h.send(8'h00, 1'b1);
		h.send(8'h00, 1'b1);
		repeat (20) @(posedge sys_clk);
		rdchk("break seq count", UECR_A_BRKERR, 16'h0002);
		chk("break seq closes", 16'(n_close), 16'h0002);
		rdchk("events", UECR_A_EVT, 16'h0009);
		wr(UECR_A_EVT, 16'h000f);
		// search command closes the open buffer, then waits for one idle
		h.send(8'h43, 1'b0);
		await(n_wr, 4);
		wr(UECR_A_CMD, 16'h0003);
		await(n_close, 3);
		rdchk("events", UECR_A_EVT, 16'h0001);
		wr(UECR_A_MAXIDLE, 16'h0002);
		h.send(8'h44, 1'b0);
		await(n_close, 4);
		chk("hunt writes", 16'(n_wr), 16'h0005);
		chk("idle flags", 16'(close_f), 16'h0002);
		// full close on the last ring entry, its event masked in the descriptor
		wr(UECR_A_EVT, 16'h000f);
		rxb_last <= 1'b1;
		rxd_int <= 1'b0;
		h.send(8'h45, 1'b0);
		await(n_close, 5);
		rxb_last <= 1'b0;
		rxd_int <= 1'b1;
		chk("full flags", 16'(close_f), 16'h0000);
		chk("rx index", 16'(rx_desc_idx), 16'h0000);
		rdchk("masked close", UECR_A_EVT, 16'h0000);
		// transmit: flow char, data, stop with breaks behind a stalled char
		wr(UECR_A_EVT, 16'h000f);
		wr(UECR_A_MODE, 16'h0800);
		wr(8'h5c, 16'h3011);
		txd_valid <= 1'b1;
		await(h.n_got, 6);
		rdchk("flow entry", 8'h5c, 16'h1011);
		rdchk("events", UECR_A_EVT, 16'h0002);
		h.stall <= 1'b1;
		repeat (6) @(posedge sys_clk);
		wr(UECR_A_BRKCNT, 16'h0002);
		wr(UECR_A_CMD, 16'h0001);
		repeat (10) @(posedge sys_clk);
		h.stall <= 1'b0;
		repeat (40) @(posedge sys_clk);
		ntx = tx_q.size();
		chk("log length", 16'(h.n_got), 16'(ntx + 3));
		chk("break one", 16'(h.rx_log[ntx + 1]), 16'h0100);
		chk("break two", 16'(h.rx_log[ntx + 2]), 16'h0100);
		// restart only after disable and stop, from the same descriptor
		wr(UECR_A_MODE, 16'h0000);
		wr(UECR_A_CMD, 16'h0002);
		wr(UECR_A_MODE, 16'h0800);
		await(h.n_got, ntx + 6);
		txd_valid <= 1'b0;
		repeat (20) @(posedge sys_clk);
		k = 0;
		nb = 0;
		foreach (h.rx_log[i]) begin
			if (h.rx_log[i][8])
				nb++;
			else if (h.rx_log[i] !== 9'h011) begin
				chk("tx char", 16'(h.rx_log[i]), 16'(tx_q[k]));
				k++;
			end
		end
		chk("tx chars", 16'(k), 16'(tx_q.size()));
		chk("breaks", 16'(nb), 16'h0002);
		chk("tx index", 16'(tx_desc_idx), 16'((tx_q.size() / 4) % 2));
		summarize();
	end
endmodule : tb
